// [shared/bridge_pm_regs.svh]
// register offsets, field positions, reset values and counts for the mode and power block
`ifndef BRIDGE_PM_REGS_SVH
`define BRIDGE_PM_REGS_SVH

// ****************************************************************
// register byte offsets
// ****************************************************************
`define OFS_CMD_STAT       12'h004
`define OFS_PM_CSR         12'h040
`define OFS_SEC_CLK_CTRL   12'h044
`define OFS_HS_CSR         12'h048
`define OFS_GPIO_CTRL      12'h04C
`define OFS_MODE_INFO      12'h050

// ****************************************************************
// field positions
// ****************************************************************
`define CMD_LO             0
`define CMD_HI             15
`define STAT_CAPABILITY_LIST_PRESENT_BIT   20
`define PM_STATE_LO        0
`define PM_STATE_HI        1
`define HS_EJECT_BIT       1
`define HS_LED_BIT         3
`define HS_INS_BIT         7
`define GPIO_OUT_BIT       0
`define GPIO_OE_BIT        1
`define GPIO_IN_BIT        2
`define MODE_LO            0
`define MODE_HI            1
`define MODE_PMREV_BIT     4
`define MODE_HSCAP_BIT     5

// ****************************************************************
// reset values and widths
// ****************************************************************
`define CMD_RESET          16'h0000
`define SEC_CLK_RESET      10'h3FF
`define SEC_CLK_COUNT      10
`define ADDR_BITS          12
`define RESP_OKAY          2'h0
`define RESP_DECERR        2'h3
`define ALL_ONES_WORD      32'hFFFFFFFF

`endif

// [shared/bridge_pm_pkg.sv]
// types shared by the mode and power block and its clock generator
package bridge_pm_pkg;

  // device power states, encoded as the power-state field
  typedef enum logic [1:0] {
    pwr_d0,
    pwr_d1,
    pwr_d2,
    pwr_d3hot
  } power_state_t;

  // operating modes chosen by the straps
  typedef enum logic [1:0] {
    mode_hot_swap,
    mode_pm11,
    mode_legacy
  } op_mode_t;

endpackage

// [shared/sec_clk_if.sv]
// carrier between the power controller and the secondary clock generator
`timescale 1ns/1ns
interface sec_clk_if #(parameter int N = 10);
  logic         source_alt;   // 1: alternate reference, 0: primary clock
  logic         halve;        // 1: divide by two
  logic         stop;         // stop every output
  logic [N-1:0] enable;       // per-output enable
  logic [N-1:0] pulses;       // one pulse per secondary clock period

  modport ctrl (output source_alt, output halve, output stop, output enable, input pulses);
  modport gen  (input source_alt, input halve, input stop, input enable, output pulses);
endinterface

// [logic/sec_clk_gen.sv]
// secondary clock generator: source select, optional halving, per-output gating
`timescale 1ns/1ns
module sec_clk_gen (
  input  wire logic ref_clk,
  input  wire logic rst_n,
  input  wire logic sec_alt_reference_clock,
  sec_clk_if.gen    clk_io
);
  import bridge_pm_pkg::*;

  logic alt_prev_r;
  logic alt_prev_nxt;
  logic half_r;
  logic half_nxt;
  logic [$bits(clk_io.pulses)-1:0] pulses_r;
  logic [$bits(clk_io.pulses)-1:0] pulses_nxt;
  logic ref_tick;
  logic out_tick;

  // ****************************************************************
  // reference tick and divider
  // ****************************************************************
  // primary source ticks every cycle, alternate source on its rising edge
  always_comb begin
    alt_prev_nxt = sec_alt_reference_clock;
    ref_tick     = clk_io.source_alt ? (sec_alt_reference_clock & ~alt_prev_r) : 1'b1;
    out_tick     = clk_io.halve ? (ref_tick & half_r) : ref_tick;
    half_nxt     = ref_tick ? ~half_r : half_r;
    // gated outputs, all held low while stopped
    pulses_nxt   = (out_tick && !clk_io.stop) ? clk_io.enable : '0;
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      alt_prev_r <= 1'b0;
      half_r     <= 1'b0;
      pulses_r   <= '0;
    end else begin
      alt_prev_r <= alt_prev_nxt;
      half_r     <= half_nxt;
      pulses_r   <= pulses_nxt;
    end
  end

  assign clk_io.pulses = pulses_r;
endmodule

// [logic/bridge_mode_power_state_control.sv]
// mode straps, power-state control, transaction gating and register slave of the bridge
//
// Functional notes
// - mode straps matter only during reset; the code samples them at the first clock edge after reset release
// - straps 00 give hot-swap, ejector on pin three
// - straps low0 high1 give power-management 1.1 mode
// - low strap 1 gives legacy mode, revision 1.0
// - extended modes support D0, D1, D2, D3hot
// - legacy mode supports only D0 and D3
// - fully operational only in D0
// - no memory or I/O claim outside D0
// - type 0 configuration accepted in every state
// - type 1 not forwarded when low; reads ones
// - error reporting stays active in low power
// - D2 and D3hot stop all secondary clocks
// - D3hot to D0 resets configuration, not vendor
// - status bit 4 reports capability list present
// - hot-swap capability entry only in hot-swap
// - hot-swap pins act only in hot-swap mode
// - each secondary clock output disabled individually
// - source select picks primary or alternate clock
// - rate select halves or passes the clock
//
// Our own choices: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ns
`include "bridge_pm_regs.svh"
module bridge_mode_power_state_control #(
  parameter int SEC_CLKS = `SEC_CLK_COUNT
) (
  input  wire logic                ref_clk,
  input  wire logic                rst_n,
  // register bus
  input  wire logic [`ADDR_BITS-1:0] s_axi_awaddr,
  input  wire logic                s_axi_awvalid,
  output logic                     s_axi_awready,
  input  wire logic [31:0]         s_axi_wdata,
  input  wire logic [3:0]          s_axi_wstrb,
  input  wire logic                s_axi_wvalid,
  output logic                     s_axi_wready,
  output logic [1:0]               s_axi_bresp,
  output logic                     s_axi_bvalid,
  input  wire logic                s_axi_bready,
  input  wire logic [`ADDR_BITS-1:0] s_axi_araddr,
  input  wire logic                s_axi_arvalid,
  output logic                     s_axi_arready,
  output logic [31:0]              s_axi_rdata,
  output logic [1:0]               s_axi_rresp,
  output logic                     s_axi_rvalid,
  input  wire logic                s_axi_rready,
  // straps and general pin
  input  wire logic                mode_strap_low,
  input  wire logic                mode_strap_high,
  input  wire logic                general_pin_three_in,
  output logic                     general_pin_three_out,
  output logic                     general_pin_three_oe,
  output logic                     insertion_notice_output,
  output logic                     removal_indicator_output,
  // transaction decode from the bus front end
  input  wire logic                mem_io_hit,
  input  wire logic                cfg0_hit,
  input  wire logic                cfg1_hit,
  input  wire logic                cfg_is_write,
  output logic                     mem_io_claim,
  output logic                     cfg0_claim,
  output logic                     cfg1_claim,
  output logic                     cfg1_forward,
  output logic                     cfg1_read_all_ones,
  // error events and state views
  input  wire logic                error_event,
  output logic                     error_report,
  output logic                     cfg_soft_reset,
  output bridge_pm_pkg::power_state_t power_state,
  output bridge_pm_pkg::op_mode_t  op_mode,
  // secondary clocks
  input  wire logic                sec_clock_source_select,
  input  wire logic                sec_clock_halve_select,
  input  wire logic                sec_alt_reference_clock,
  output logic [SEC_CLKS-1:0]      sec_clock_outputs
);
  import bridge_pm_pkg::*;

  // ****************************************************************
  // state
  // ****************************************************************
  logic                strap_taken_r;
  logic                strap_taken_nxt;
  op_mode_t            mode_r;
  op_mode_t            mode_nxt;
  power_state_t        pstate_r;
  power_state_t        pstate_nxt;
  logic [15:0]         cmd_r;
  logic [15:0]         cmd_nxt;
  logic [SEC_CLKS-1:0] clk_en_r;
  logic [SEC_CLKS-1:0] clk_en_nxt;
  logic                led_r;
  logic                led_nxt;
  logic                ins_r;
  logic                ins_nxt;
  logic                eject_prev_r;
  logic                eject_prev_nxt;
  logic                gpio_out_r;
  logic                gpio_out_nxt;
  logic                gpio_oe_r;
  logic                gpio_oe_nxt;
  logic                soft_rst_r;
  logic                soft_rst_nxt;
  logic                err_r;
  logic                err_nxt;
  logic                bvalid_r;
  logic                bvalid_nxt;
  logic [1:0]          bresp_r;
  logic [1:0]          bresp_nxt;
  logic                rvalid_r;
  logic                rvalid_nxt;
  logic [1:0]          rresp_r;
  logic [1:0]          rresp_nxt;
  logic [31:0]         rdata_r;
  logic [31:0]         rdata_nxt;

  logic                hs_mode;
  logic                wr_take;
  logic                rd_take;
  logic [31:0]         wmask;
  logic                ejector_switch_input;
  logic                eject_change;
  logic                ins_clear;
  power_state_t        req_state;
  logic                req_ok;

  sec_clk_if #(.N(SEC_CLKS)) clk_io ();

  // ****************************************************************
  // mode straps
  // ****************************************************************
  // straps taken at the first edge after release, then frozen
  always_comb begin
    strap_taken_nxt = 1'b1;
    mode_nxt        = mode_r;
    if (!strap_taken_r) begin
      if (mode_strap_low) begin
        mode_nxt = mode_legacy;
      end else if (mode_strap_high) begin
        mode_nxt = mode_pm11;
      end else begin
        mode_nxt = mode_hot_swap;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      strap_taken_r <= 1'b0;
      mode_r        <= mode_legacy;
    end else begin
      strap_taken_r <= strap_taken_nxt;
      mode_r        <= mode_nxt;
    end
  end

  assign hs_mode = (mode_r == mode_hot_swap);

  // ****************************************************************
  // bus handshakes
  // ****************************************************************
  // write taken only when address and data are both offered
  assign wr_take       = s_axi_awvalid && s_axi_wvalid && !bvalid_r;
  assign rd_take       = s_axi_arvalid && !rvalid_r;
  assign s_axi_awready = wr_take;
  assign s_axi_wready  = wr_take;
  assign s_axi_arready = rd_take;
  assign wmask         = {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}},
                          {8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};
  assign req_state     = power_state_t'(s_axi_wdata[`PM_STATE_HI:`PM_STATE_LO]);
  // legacy mode refuses the intermediate states
  assign req_ok        = (mode_r != mode_legacy)
                         || (req_state == pwr_d0) || (req_state == pwr_d3hot);

  // ****************************************************************
  // control registers and power state
  // ****************************************************************
  assign ejector_switch_input = hs_mode & general_pin_three_in;
  assign eject_change = hs_mode && (ejector_switch_input != eject_prev_r);
  assign ins_clear    = wr_take && (s_axi_awaddr == `OFS_HS_CSR) && s_axi_wstrb[0]
                        && s_axi_wdata[`HS_INS_BIT];

  always_comb begin
    pstate_nxt     = pstate_r;
    cmd_nxt        = cmd_r;
    clk_en_nxt     = clk_en_r;
    led_nxt        = led_r;
    gpio_out_nxt   = gpio_out_r;
    gpio_oe_nxt    = gpio_oe_r;
    soft_rst_nxt   = 1'b0;
    eject_prev_nxt = ejector_switch_input;
    err_nxt        = error_event;
    // event set wins over software clear
    ins_nxt        = eject_change ? 1'b1 : (ins_clear ? 1'b0 : ins_r);
    if (wr_take) begin
      if (s_axi_awaddr == `OFS_CMD_STAT) begin
        cmd_nxt = (cmd_r & ~wmask[15:0]) | (s_axi_wdata[15:0] & wmask[15:0]);
      end else if (s_axi_awaddr == `OFS_PM_CSR) begin
        if (s_axi_wstrb[0] && req_ok) begin
          pstate_nxt = req_state;
          // leaving D3hot for D0 restores the configuration defaults
          if (pstate_r == pwr_d3hot && req_state == pwr_d0) begin
            soft_rst_nxt = 1'b1;
            cmd_nxt      = `CMD_RESET;
          end
        end
      end else if (s_axi_awaddr == `OFS_SEC_CLK_CTRL) begin
        clk_en_nxt = (clk_en_r & ~wmask[SEC_CLKS-1:0])
                     | (s_axi_wdata[SEC_CLKS-1:0] & wmask[SEC_CLKS-1:0]);
      end else if (s_axi_awaddr == `OFS_HS_CSR) begin
        if (s_axi_wstrb[0] && hs_mode) begin
          led_nxt = s_axi_wdata[`HS_LED_BIT];
        end
      end else if (s_axi_awaddr == `OFS_GPIO_CTRL) begin
        if (s_axi_wstrb[0]) begin
          gpio_out_nxt = s_axi_wdata[`GPIO_OUT_BIT];
          gpio_oe_nxt  = s_axi_wdata[`GPIO_OE_BIT];
        end
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pstate_r     <= pwr_d0;
      cmd_r        <= `CMD_RESET;
      clk_en_r     <= `SEC_CLK_RESET;
      led_r        <= 1'b0;
      ins_r        <= 1'b0;
      eject_prev_r <= 1'b0;
      gpio_out_r   <= 1'b0;
      gpio_oe_r    <= 1'b0;
      soft_rst_r   <= 1'b0;
      err_r        <= 1'b0;
    end else begin
      pstate_r     <= pstate_nxt;
      cmd_r        <= cmd_nxt;
      clk_en_r     <= clk_en_nxt;
      led_r        <= led_nxt;
      ins_r        <= ins_nxt;
      eject_prev_r <= eject_prev_nxt;
      gpio_out_r   <= gpio_out_nxt;
      gpio_oe_r    <= gpio_oe_nxt;
      soft_rst_r   <= soft_rst_nxt;
      err_r        <= err_nxt;
    end
  end

  // ****************************************************************
  // responses
  // ****************************************************************
  // one outstanding write and one outstanding read
  always_comb begin
    bvalid_nxt = bvalid_r;
    bresp_nxt  = bresp_r;
    rvalid_nxt = rvalid_r;
    rresp_nxt  = rresp_r;
    rdata_nxt  = rdata_r;
    if (bvalid_r && s_axi_bready) begin
      bvalid_nxt = 1'b0;
    end
    if (wr_take) begin
      bvalid_nxt = 1'b1;
      if (s_axi_awaddr == `OFS_CMD_STAT || s_axi_awaddr == `OFS_PM_CSR
          || s_axi_awaddr == `OFS_SEC_CLK_CTRL || s_axi_awaddr == `OFS_HS_CSR
          || s_axi_awaddr == `OFS_GPIO_CTRL || s_axi_awaddr == `OFS_MODE_INFO) begin
        bresp_nxt = `RESP_OKAY;
      end else begin
        bresp_nxt = `RESP_DECERR;
      end
    end
    if (rvalid_r && s_axi_rready) begin
      rvalid_nxt = 1'b0;
    end
    if (rd_take) begin
      rvalid_nxt = 1'b1;
      rresp_nxt  = `RESP_OKAY;
      rdata_nxt  = '0;
      if (s_axi_araddr == `OFS_CMD_STAT) begin
        rdata_nxt[`CMD_HI:`CMD_LO]   = cmd_r;
        rdata_nxt[`STAT_CAPABILITY_LIST_PRESENT_BIT] = 1'b1;
      end else if (s_axi_araddr == `OFS_PM_CSR) begin
        rdata_nxt[`PM_STATE_HI:`PM_STATE_LO] = pstate_r;
      end else if (s_axi_araddr == `OFS_SEC_CLK_CTRL) begin
        rdata_nxt[SEC_CLKS-1:0] = clk_en_r;
      end else if (s_axi_araddr == `OFS_HS_CSR) begin
        // hot-swap entry reads zero outside hot-swap mode
        rdata_nxt[`HS_EJECT_BIT] = ejector_switch_input;
        rdata_nxt[`HS_LED_BIT]   = led_r & hs_mode;
        rdata_nxt[`HS_INS_BIT]   = ins_r & hs_mode;
      end else if (s_axi_araddr == `OFS_GPIO_CTRL) begin
        rdata_nxt[`GPIO_OUT_BIT] = gpio_out_r;
        rdata_nxt[`GPIO_OE_BIT]  = gpio_oe_r;
        rdata_nxt[`GPIO_IN_BIT]  = general_pin_three_in;
      end else if (s_axi_araddr == `OFS_MODE_INFO) begin
        rdata_nxt[`MODE_HI:`MODE_LO]  = mode_r;
        rdata_nxt[`MODE_PMREV_BIT]    = (mode_r != mode_legacy);
        rdata_nxt[`MODE_HSCAP_BIT]    = hs_mode;
      end else begin
        rresp_nxt = `RESP_DECERR;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      bvalid_r <= 1'b0;
      bresp_r  <= `RESP_OKAY;
      rvalid_r <= 1'b0;
      rresp_r  <= `RESP_OKAY;
      rdata_r  <= '0;
    end else begin
      bvalid_r <= bvalid_nxt;
      bresp_r  <= bresp_nxt;
      rvalid_r <= rvalid_nxt;
      rresp_r  <= rresp_nxt;
      rdata_r  <= rdata_nxt;
    end
  end

  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp  = bresp_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rresp  = rresp_r;
  assign s_axi_rdata  = rdata_r;

  // ****************************************************************
  // transaction gating and pins
  // ****************************************************************
  assign mem_io_claim       = mem_io_hit && (pstate_r == pwr_d0);
  assign cfg0_claim         = cfg0_hit;
  assign cfg1_claim         = cfg1_hit;
  assign cfg1_forward       = cfg1_hit && (pstate_r == pwr_d0);
  assign cfg1_read_all_ones = cfg1_hit && !cfg_is_write && (pstate_r != pwr_d0);
  assign error_report       = err_r;
  assign cfg_soft_reset     = soft_rst_r;
  assign power_state        = pstate_r;
  assign op_mode            = mode_r;

  // pin three is forced to an input while it serves as the ejector switch
  assign general_pin_three_out    = gpio_out_r;
  assign general_pin_three_oe     = gpio_oe_r & ~hs_mode;
  assign insertion_notice_output  = ins_r & hs_mode;
  assign removal_indicator_output = led_r & hs_mode;

  // ****************************************************************
  // secondary clocks
  // ****************************************************************
  assign clk_io.source_alt = sec_clock_source_select;
  assign clk_io.halve      = ~sec_clock_halve_select;
  assign clk_io.stop       = (pstate_r == pwr_d2) || (pstate_r == pwr_d3hot);
  assign clk_io.enable     = clk_en_r;
  assign sec_clock_outputs = clk_io.pulses;

  sec_clk_gen u_sec_clk_gen (
    .ref_clk                 (ref_clk),
    .rst_n                   (rst_n),
    .sec_alt_reference_clock (sec_alt_reference_clock),
    .clk_io                  (clk_io)
  );
endmodule

// [tb/bridge_pm_monitor.sv]
// port-level checks on the mode and power block
`timescale 1ns/1ns
module bridge_pm_monitor #(
  parameter int SEC_CLKS = 10
) (
  input wire logic                         ref_clk,
  input wire logic                         rst_n,
  input wire logic                         mem_io_hit,
  input wire logic                         cfg0_hit,
  input wire logic                         cfg1_hit,
  input wire logic                         cfg_is_write,
  input wire logic                         mem_io_claim,
  input wire logic                         cfg0_claim,
  input wire logic                         cfg1_claim,
  input wire logic                         cfg1_forward,
  input wire logic                         cfg1_read_all_ones,
  input wire logic                         error_event,
  input wire logic                         error_report,
  input wire logic                         cfg_soft_reset,
  input wire logic                         insertion_notice_output,
  input wire logic                         removal_indicator_output,
  input wire logic                         general_pin_three_oe,
  input wire bridge_pm_pkg::power_state_t  power_state,
  input wire bridge_pm_pkg::op_mode_t      op_mode,
  input wire logic [SEC_CLKS-1:0]          sec_clock_outputs
);
  import bridge_pm_pkg::*;
  // ****
  // assertions
  // ****
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  a_memio_gate: assert property (mem_io_claim == (mem_io_hit && power_state == pwr_d0))
    else $error("memory or io claim wrong");
  a_cfg0_accept: assert property (cfg0_hit |-> cfg0_claim)
    else $error("type 0 access not claimed");
  a_cfg1_block: assert property (cfg1_hit |-> cfg1_claim && cfg1_forward == (power_state == pwr_d0))
    else $error("type 1 forward wrong");
  a_cfg1_ones: assert property (cfg1_read_all_ones == (cfg1_hit && !cfg_is_write && power_state != pwr_d0))
    else $error("type 1 ones read wrong");
  a_err_follow: assert property ($past(rst_n) |-> error_report == $past(error_event))
    else $error("error report lost");
  a_clk_stop: assert property (power_state inside {pwr_d2, pwr_d3hot} && $past(power_state) inside {pwr_d2, pwr_d3hot} |-> sec_clock_outputs == '0)
    else $error("secondary clock running while stopped");
  a_mode_hold: assert property ($past(rst_n, 2) |-> $stable(op_mode))
    else $error("mode changed outside reset");
  a_legacy_states: assert property (op_mode == mode_legacy |-> power_state inside {pwr_d0, pwr_d3hot})
    else $error("legacy mode in intermediate state");
  a_soft_pulse: assert property (power_state == pwr_d0 && $past(power_state) == pwr_d3hot |-> ##[0:2] cfg_soft_reset ##1 !cfg_soft_reset)
    else $error("soft reset pulse missing");
  a_hs_pins: assert property (op_mode != mode_hot_swap |-> !insertion_notice_output && !removal_indicator_output)
    else $error("hot-swap output active outside hot-swap");
  a_pin_input: assert property (op_mode == mode_hot_swap |-> !general_pin_three_oe)
    else $error("pin three driven in hot-swap");
  // main scenarios reached
  c_soft: cover property (cfg_soft_reset);
  c_ones: cover property (cfg1_read_all_ones);
  c_insert: cover property (op_mode == mode_hot_swap && insertion_notice_output);
endmodule

// [tb/sec_side_model.sv]
// far side: free-running alternate reference and fed-back clock counter
`timescale 1ns/1ns
module sec_side_model #(
  parameter int HALF = 4
) (
  input  wire logic        ref_clk,
  input  wire logic        fb_clock,
  input  wire logic        cnt_clr,
  output logic             alt_ref,
  output logic [15:0]      fb_count
);
  int ph = 0;
  initial alt_ref = 1'b0;
  // reference toggles every HALF cycles, runs free
  always @(posedge ref_clk) begin
    ph <= (ph == HALF - 1) ? 0 : ph + 1;
    if (ph == HALF - 1) begin
      alt_ref <= !alt_ref;
    end
  end
  // count pulses of the output fed back to the clock input
  always @(posedge ref_clk) begin
    fb_count <= cnt_clr ? 16'h0000 : fb_count + 16'(fb_clock);
  end
endmodule

// [tb/bridge_mode_power_state_control_tb.sv]
// self-checking bench for the mode and power block
`timescale 1ns/1ns
`include "bridge_pm_regs.svh"
module bridge_mode_power_state_control_tb;
  import bridge_pm_pkg::*;
  localparam int ALT_HALF = 4;
  logic ref_clk, rst_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic mode_strap_low, mode_strap_high, general_pin_three_in, general_pin_three_out;
  logic general_pin_three_oe, insertion_notice_output, removal_indicator_output;
  logic mem_io_hit, cfg0_hit, cfg1_hit, cfg_is_write, mem_io_claim, cfg0_claim, cfg1_claim;
  logic cfg1_forward, cfg1_read_all_ones, error_event, error_report, cfg_soft_reset;
  logic sec_clock_source_select, sec_clock_halve_select, sec_alt_reference_clock, cnt_clr;
  logic [11:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0]  s_axi_wdata, s_axi_rdata, rd;
  logic [3:0]   s_axi_wstrb;
  logic [1:0]   s_axi_bresp, s_axi_rresp, rs;
  logic [9:0]   sec_clock_outputs;
  logic [15:0]  fb_count;
  power_state_t power_state;
  op_mode_t     op_mode;
  int           miscompares = 0;
  int           n_checks = 0;
  logic [31:0]  exp_cnt [4] = '{32, 64, 16 / ALT_HALF, 32 / ALT_HALF};

  bridge_mode_power_state_control bridge_mode_power_state_control_i (.*);
  sec_side_model #(.HALF(ALT_HALF)) sec_side_model_i (.ref_clk(ref_clk),
    .fb_clock(sec_clock_outputs[0]), .cnt_clr(cnt_clr), .alt_ref(sec_alt_reference_clock),
    .fb_count(fb_count));

  // ****
  // tasks
  // ****
  task automatic complete_run;
    if (miscompares == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // write cycle, both channels offered together
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    @(posedge ref_clk iff s_axi_awready);
    {s_axi_awvalid, s_axi_wvalid} <= 2'h0;
    @(posedge ref_clk iff s_axi_bvalid);
    rs = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rdreg(input logic [11:0] a);
    @(posedge ref_clk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    @(posedge ref_clk iff s_axi_arready);
    s_axi_arvalid <= 1'b0;
    @(posedge ref_clk iff s_axi_rvalid);
    rd = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
    rdreg(a);
    chk(rd, exp);
  endtask
  // straps only set while held in reset, moved after release
  task automatic do_reset(input logic lo, input logic hi);
    @(posedge ref_clk);
    rst_n <= 1'b0;
    {mode_strap_low, mode_strap_high} <= {lo, hi};
    repeat (20) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
    {mode_strap_low, mode_strap_high} <= {!lo, !hi};
  endtask
  // all decodes hit with an error event; claim, cfg0, forward, ones
  task automatic gate(input logic [3:0] exp);
    @(posedge ref_clk);
    {mem_io_hit, cfg0_hit, cfg1_hit, error_event} <= 4'hF;
    @(posedge ref_clk);
    #1;
    chk({mem_io_claim, cfg0_claim, cfg1_forward, cfg1_read_all_ones, error_report},
        {27'h0, exp, 1'b1});
    @(posedge ref_clk);
    {mem_io_hit, cfg0_hit, cfg1_hit, error_event} <= 4'h0;
  endtask
  // pulses of the fed-back output over 64 cycles
  task automatic measure(input logic [31:0] exp);
    repeat (20) @(posedge ref_clk);
    cnt_clr <= 1'b1;
    @(posedge ref_clk);
    cnt_clr <= 1'b0;
    repeat (64) @(posedge ref_clk);
    #1;
    chk({16'h0, fb_count}, exp);
  endtask

  // ****
  // clock, watchdog, tests
  // ****
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  initial begin
    repeat (8000) @(posedge ref_clk);
    miscompares++;
    complete_run();
  end
  initial begin
    {rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {mode_strap_low, mode_strap_high, general_pin_three_in, cfg_is_write} = '0;
    {mem_io_hit, cfg0_hit, cfg1_hit, error_event, cnt_clr} = '0;
    {sec_clock_source_select, sec_clock_halve_select} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hF;
    do_reset(1'b0, 1'b0);
    rchk(`OFS_MODE_INFO, 32'h0000_0030);
    rchk(`OFS_CMD_STAT, 32'h0010_0000);
    rchk(`OFS_SEC_CLK_CTRL, 32'h0000_03FF);
    @(posedge ref_clk);
    general_pin_three_in <= 1'b1;
    rchk(`OFS_HS_CSR, 32'h0000_0082);
    wr(`OFS_HS_CSR, 32'h0000_0088);
    rchk(`OFS_HS_CSR, 32'h0000_000A);
    chk({30'h0, insertion_notice_output, removal_indicator_output}, 32'h1);
    wr(`OFS_GPIO_CTRL, 32'h0000_0003);
    wr(`OFS_CMD_STAT, 32'h0000_0147);
    wr(`OFS_SEC_CLK_CTRL, 32'h0000_03FE);
    gate(4'hE);
    for (int s = 1; s < 4; s++) begin
      wr(`OFS_PM_CSR, 32'(s));
      rchk(`OFS_PM_CSR, 32'(s));
      gate(4'h5);
    end
    wr(`OFS_PM_CSR, 32'h0);
    rchk(`OFS_CMD_STAT, 32'h0010_0000);
    rchk(`OFS_SEC_CLK_CTRL, 32'h0000_03FE);
    measure(32'h0);
    do_reset(1'b0, 1'b1);
    rchk(`OFS_MODE_INFO, 32'h0000_0011);
    wr(`OFS_GPIO_CTRL, 32'h0000_0003);
    @(posedge ref_clk);
    general_pin_three_in <= 1'b0;
    rchk(`OFS_GPIO_CTRL, 32'h0000_0003);
    chk({30'h0, general_pin_three_out, general_pin_three_oe}, 32'h3);
    chk({31'h0, insertion_notice_output}, 32'h0);
    for (int k = 0; k < 4; k++) begin
      @(posedge ref_clk);
      {sec_clock_source_select, sec_clock_halve_select} <= 2'(k);
      measure(exp_cnt[k]);
    end
    wr(`OFS_PM_CSR, 32'h2);
    measure(32'h0);
    do_reset(1'b1, 1'b1);
    rchk(`OFS_MODE_INFO, 32'h0000_0002);
    for (int s = 1; s < 3; s++) begin
      wr(`OFS_PM_CSR, 32'(s));
      rchk(`OFS_PM_CSR, 32'h0);
    end
    wr(`OFS_PM_CSR, 32'h3);
    rchk(`OFS_PM_CSR, 32'h3);
    wr(`OFS_HS_CSR, 32'h0000_0008);
    chk({31'h0, removal_indicator_output}, 32'h0);
    wr(12'h100, 32'h0000_0001);
    chk({30'h0, rs}, {30'h0, `RESP_DECERR});
    rdreg(12'h100);
    chk({rs, rd[29:0]}, {`RESP_DECERR, 30'h0});
    complete_run();
  end
endmodule

bind bridge_mode_power_state_control bridge_pm_monitor #(.SEC_CLKS(SEC_CLKS)) bridge_pm_monitor_i (.*);
